/* pre_pkg.sv */
// Constants and types for the root-complex event and bridge response block.
// Assumes a single 40 MHz core clock and an AXI4-Lite register master.
//
// Behaviour
// - Each vector status register holds 32 bits.
// - Arrival sets a bit; writing one clears it.
// - Set wins over a same-cycle clear.
// - Clearing one bit while another sets works.
// - Keep first PME requester ID until cleared.
// - Second PME sets status and pending bits.
// - Timed-out request gets bridge error response.
// - Timeouts arrive on their own interface.
// - Completion first; same-cycle timeout held, later.
// - Deferred timeouts queue up to 4; more are lost.
// - Read buffer limit set by parameter.
// - Oversized inbound read answered completer abort.
package pre_pkg;

	localparam int VEC_W      = 32;
	localparam int TAG_W      = 8;
	localparam int RID_W      = 16;
	localparam int LEN_W      = 13;
	localparam int MAX_RD_B   = 512;
	localparam int TO_DEPTH   = 4;

	localparam logic [7:0] A_VEC0    = 8'h00;
	localparam logic [7:0] A_VEC1    = 8'h04;
	localparam logic [7:0] A_ROOTST  = 8'h08;
	localparam logic [7:0] A_CTRL    = 8'h0c;
	localparam logic [7:0] A_BRSTAT  = 8'h10;

	localparam int RS_PME_STATUS = 16;
	localparam int RS_PME_PEND   = 17;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	localparam logic [2:0] CPL_SC = 3'h0;
	localparam logic [2:0] CPL_UR = 3'h1;
	localparam logic [2:0] CPL_CA = 3'h4;

	localparam logic [31:0] CTRL_RST = 32'h0000_0001;

	typedef enum logic [1:0] {
		PRE_AX_IDLE,
		PRE_AX_BRESP,
		PRE_AX_RRESP
	} pre_ax_t;

endpackage

/* pre_fifo.sv */
// Small FIFO memory used to queue PME requester IDs and deferred timeouts.
// Assumes the writer checks full and the reader checks empty.
`timescale 1ns/1ps
module pre_fifo #(
	parameter int W = 16,
	parameter int D = 4
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic         ce,
	// Write side
	input  wire logic         wr,
	input  wire logic [W-1:0] wdata,
	output logic              full,
	// Read side
	input  wire logic         rd,
	output logic [W-1:0]      rdata,
	output logic              empty
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
		logic [W-1:0]  head;
	} pre_fifo_t;

	logic [W-1:0] mem [D];
	pre_fifo_t    s;
	pre_fifo_t    next_s;

	always_comb begin
		next_s = s;
		if (wr && !full) begin
			next_s.wp = AW'(s.wp + 1'b1);
		end
		if (rd && !empty) begin
			next_s.rp = AW'(s.rp + 1'b1);
		end
		next_s.cnt = (AW+1)'(s.cnt + (wr && !full) - (rd && !empty));
		next_s.head = mem[next_s.rp];
		if (wr && !full && (next_s.cnt == (AW+1)'(1))) begin
			next_s.head = wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
			if (wr && !full) begin
				mem[s.wp] <= wdata;
			end
		end
	end

	assign full  = (s.cnt == (AW+1)'(D));
	assign empty = (s.cnt == '0);
	assign rdata = s.head;

endmodule // pre_fifo

/* pre_top.sv */
// Root-complex event logging and bridge response logic with AXI4-Lite registers.
// Assumes MSI, PME, completion and timeout strobes come from core-clock logic.
`timescale 1ns/1ps
module pre_top #(
	parameter int MAX_INBOUND_READ_BYTES = pre_pkg::MAX_RD_B
) (
	// Clock, reset, enable
	input  wire logic                      clk,
	input  wire logic                      srst,
	input  wire logic                      ce,
	// AXI4-Lite slave
	input  wire logic [7:0]                s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [7:0]                s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	// MSI receiver
	input  wire logic                      msi_valid,
	input  wire logic [5:0]                msi_vector,
	// PME message receiver
	input  wire logic                      pme_valid,
	input  wire logic [pre_pkg::RID_W-1:0] pme_rid,
	// Outbound completion and timeout paths
	input  wire logic                      cpl_valid,
	input  wire logic [pre_pkg::TAG_W-1:0] cpl_tag,
	input  wire logic                      cto_valid,
	input  wire logic [pre_pkg::TAG_W-1:0] cto_tag,
	// Slave-side response to outbound requests
	output logic                           resp_valid,
	output logic [pre_pkg::TAG_W-1:0]      resp_tag,
	output logic                           resp_err,
	// Inbound memory read check
	input  wire logic                      ird_valid,
	input  wire logic [pre_pkg::LEN_W-1:0] ird_bytes,
	output logic                           ird_done,
	output logic [2:0]                     ird_status
);
	localparam int VW = pre_pkg::VEC_W;

	typedef struct packed {
		pre_pkg::pre_ax_t            ax;
		logic [31:0]                 rdata;
		logic [1:0]                  resp;
		logic                        awready;
		logic                        wready;
		logic                        arready;
		logic                        bvalid;
		logic                        rvalid;
		logic [VW-1:0]               vec0;
		logic [VW-1:0]               vec1;
		logic [31:0]                 ctrl;
		logic                        pme_st;
		logic [pre_pkg::RID_W-1:0]   pme_id;
		logic [15:0]                 to_count;
		logic                        resp_valid;
		logic [pre_pkg::TAG_W-1:0]   resp_tag;
		logic                        resp_err;
		logic                        ird_done;
		logic [2:0]                  ird_status;
	} pre_top_t;

	pre_top_t s;
	pre_top_t next_s;

	logic                      pq_full;
	logic                      pq_empty;
	logic [pre_pkg::RID_W-1:0] pq_head;
	logic                      pq_wr;
	logic                      pq_rd;
	logic                      tq_full;
	logic                      tq_empty;
	logic [pre_pkg::TAG_W-1:0] tq_head;
	logic                      tq_wr;
	logic                      tq_rd;
	logic                      wr_go;
	logic                      rd_go;
	logic [31:0]               w1c;
	logic                      pme_clr;

	// ----------------------------------------------------------------
	// Byte-lane mask for register writes.
	// ----------------------------------------------------------------
	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		return m;
	endfunction

	// ----------------------------------------------------------------
	// Vector status update: set wins per bit, other bits clear freely.
	// ----------------------------------------------------------------
	function automatic logic [VW-1:0] vec_next(input logic [VW-1:0] cur,
	                                           input logic [VW-1:0] set,
	                                           input logic [VW-1:0] clr);
		return (cur & ~clr) | set;
	endfunction

	// ----------------------------------------------------------------
	// Queues for PME requester IDs and deferred timeouts.
	// ----------------------------------------------------------------
	pre_fifo #(
		.W (pre_pkg::RID_W),
		.D (pre_pkg::TO_DEPTH)
	) u_pme_q (
		.clk   (clk),
		.srst  (srst),
		.ce    (ce),
		.wr    (pq_wr),
		.wdata (pme_rid),
		.full  (pq_full),
		.rd    (pq_rd),
		.rdata (pq_head),
		.empty (pq_empty)
	);

	pre_fifo #(
		.W (pre_pkg::TAG_W),
		.D (pre_pkg::TO_DEPTH)
	) u_to_q (
		.clk   (clk),
		.srst  (srst),
		.ce    (ce),
		.wr    (tq_wr),
		.wdata (cto_tag),
		.full  (tq_full),
		.rd    (tq_rd),
		.rdata (tq_head),
		.empty (tq_empty)
	);

	// ----------------------------------------------------------------
	// Next-state logic.
	// ----------------------------------------------------------------
	always_comb begin
		logic [VW-1:0] set0;
		logic [VW-1:0] set1;
		logic [VW-1:0] clr0;
		logic [VW-1:0] clr1;
		logic          to_now;
		set0   = '0;
		set1   = '0;
		clr0   = '0;
		clr1   = '0;
		to_now = 1'b0;
		next_s = s;
		wr_go  = s.awready && s.wready && s_axi_awvalid && s_axi_wvalid;
		rd_go  = s.arready && s_axi_arvalid;
		w1c    = s_axi_wdata & lane_mask(s_axi_wstrb);
		pme_clr = 1'b0;
		pq_wr  = 1'b0;
		pq_rd  = 1'b0;
		tq_wr  = 1'b0;
		tq_rd  = 1'b0;

		// ----------------------------------------------------------------
		// Message-signalled interrupt arrival, two 32-bit banks.
		// ----------------------------------------------------------------
		if (msi_valid && s.ctrl[0]) begin
			if (msi_vector[5]) begin
				set1[msi_vector[4:0]] = 1'b1;
			end else begin
				set0[msi_vector[4:0]] = 1'b1;
			end
		end

		// ----------------------------------------------------------------
		// AXI4-Lite handshakes: one write or one read at a time.
		// ----------------------------------------------------------------
		next_s.awready = 1'b0;
		next_s.wready  = 1'b0;
		next_s.arready = 1'b0;
		case (s.ax)
			pre_pkg::PRE_AX_IDLE: begin
				if (wr_go) begin
					next_s.resp = pre_pkg::RESP_OKAY;
					case (s_axi_awaddr)
						pre_pkg::A_VEC0: clr0 = w1c;
						pre_pkg::A_VEC1: clr1 = w1c;
						pre_pkg::A_ROOTST: pme_clr = w1c[pre_pkg::RS_PME_STATUS];
						pre_pkg::A_CTRL: begin
							next_s.ctrl = (s.ctrl & ~lane_mask(s_axi_wstrb)) | w1c;
						end
						pre_pkg::A_BRSTAT: ;
						default: next_s.resp = pre_pkg::RESP_DECERR;
					endcase
					next_s.ax = pre_pkg::PRE_AX_BRESP;
				end else if (rd_go) begin
					next_s.resp = pre_pkg::RESP_OKAY;
					case (s_axi_araddr)
						pre_pkg::A_VEC0:   next_s.rdata = s.vec0;
						pre_pkg::A_VEC1:   next_s.rdata = s.vec1;
						pre_pkg::A_ROOTST: begin
							next_s.rdata = {14'h0, s.pme_st && !pq_empty,
							                s.pme_st, s.pme_id};
						end
						pre_pkg::A_CTRL:   next_s.rdata = s.ctrl;
						pre_pkg::A_BRSTAT: begin
							next_s.rdata = {13'h0, pq_empty, tq_empty, tq_full, s.to_count};
						end
						default: begin
							next_s.rdata = 32'h0000_0000;
							next_s.resp  = pre_pkg::RESP_DECERR;
						end
					endcase
					next_s.ax = pre_pkg::PRE_AX_RRESP;
				end else begin
					// Offer one channel at a time so a read is never lost to a write.
					next_s.arready = !(s_axi_awvalid || s_axi_wvalid);
					next_s.awready = !next_s.arready;
					next_s.wready  = !next_s.arready;
				end
			end
			pre_pkg::PRE_AX_BRESP: begin
				if (s_axi_bready) begin
					next_s.ax = pre_pkg::PRE_AX_IDLE;
				end
			end
			pre_pkg::PRE_AX_RRESP: begin
				if (s_axi_rready) begin
					next_s.ax = pre_pkg::PRE_AX_IDLE;
				end
			end
			default: next_s.ax = pre_pkg::PRE_AX_IDLE;
		endcase
		if (s.ax == pre_pkg::PRE_AX_IDLE && (wr_go || rd_go)) begin
			next_s.awready = 1'b0;
			next_s.wready  = 1'b0;
			next_s.arready = 1'b0;
		end
		next_s.bvalid = (next_s.ax == pre_pkg::PRE_AX_BRESP);
		next_s.rvalid = (next_s.ax == pre_pkg::PRE_AX_RRESP);

		// ----------------------------------------------------------------
		// Vector status registers.
		// ----------------------------------------------------------------
		next_s.vec0 = vec_next(s.vec0, set0, clr0);
		next_s.vec1 = vec_next(s.vec1, set1, clr1);

		// ----------------------------------------------------------------
		// Power-management event logging with requester ID queue.
		// ----------------------------------------------------------------
		if (pme_clr && s.pme_st) begin
			if (!pq_empty) begin
				next_s.pme_id = pq_head;
				next_s.pme_st = 1'b1;
				pq_rd         = 1'b1;
			end else begin
				next_s.pme_st = 1'b0;
			end
		end
		if (pme_valid) begin
			if (!next_s.pme_st) begin
				next_s.pme_st = 1'b1;
				next_s.pme_id = pme_rid;
			end else begin
				pq_wr = 1'b1;
			end
		end

		// ----------------------------------------------------------------
		// Outbound completion and timeout response arbitration.
		// ----------------------------------------------------------------
		next_s.resp_valid = 1'b0;
		next_s.resp_err   = 1'b0;
		if (cpl_valid) begin
			next_s.resp_valid = 1'b1;
			next_s.resp_tag   = cpl_tag;
			tq_wr             = cto_valid;
		end else if (!tq_empty) begin
			next_s.resp_valid = 1'b1;
			next_s.resp_err   = 1'b1;
			next_s.resp_tag   = tq_head;
			tq_rd             = 1'b1;
			tq_wr             = cto_valid;
		end else if (cto_valid) begin
			to_now            = 1'b1;
			next_s.resp_valid = 1'b1;
			next_s.resp_err   = 1'b1;
			next_s.resp_tag   = cto_tag;
		end
		if (next_s.resp_err) begin
			next_s.to_count = 16'(s.to_count + 1'b1);
		end
		if (to_now) begin
			next_s.resp_tag = cto_tag;
		end

		// ----------------------------------------------------------------
		// Inbound memory read size check.
		// ----------------------------------------------------------------
		next_s.ird_done = ird_valid;
		if (ird_valid) begin
			if (32'(ird_bytes) > MAX_INBOUND_READ_BYTES) begin
				next_s.ird_status = pre_pkg::CPL_CA;
			end else begin
				next_s.ird_status = pre_pkg::CPL_SC;
			end
		end
	end

	// ----------------------------------------------------------------
	// State register.
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			s      <= '0;
			s.ctrl <= pre_pkg::CTRL_RST;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all from flip-flops.
	// ----------------------------------------------------------------
	assign s_axi_awready = s.awready;
	assign s_axi_wready  = s.wready;
	assign s_axi_arready = s.arready;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.resp;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rresp   = s.resp;
	assign s_axi_rdata   = s.rdata;
	assign resp_valid    = s.resp_valid;
	assign resp_tag      = s.resp_tag;
	assign resp_err      = s.resp_err;
	assign ird_done      = s.ird_done;
	assign ird_status    = s.ird_status;

endmodule // pre_top

/* pre_top_chk.sv */
// Port checks for pre_top, attached by bind.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module pre_top_chk #(
	parameter int MAX_INBOUND_READ_BYTES = 512
) (
	// Clock and control
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        ce,
	// Register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Bridge and inbound reads
	input wire logic        cpl_valid,
	input wire logic [7:0]  cpl_tag,
	input wire logic        cto_valid,
	input wire logic        resp_valid,
	input wire logic [7:0]  resp_tag,
	input wire logic        resp_err,
	input wire logic        ird_valid,
	input wire logic [12:0] ird_bytes,
	input wire logic        ird_done,
	input wire logic [2:0]  ird_status
);
	// ----------------------------------------
	// Assertions.
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	wr_answer_a: assert property (ce && s_axi_awvalid && s_axi_wvalid && s_axi_awready
		&& s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rresp)) else $error("read answer dropped");
	unmap_read_a: assert property (ce && s_axi_arvalid && s_axi_arready && !s_axi_awvalid
		&& s_axi_araddr > 8'h10 |=> s_axi_rresp == pre_pkg::RESP_DECERR) else $error("no decode error");
	ird_abort_a: assert property (ce && ird_valid && ird_bytes > MAX_INBOUND_READ_BYTES
		|=> ird_done && ird_status == pre_pkg::CPL_CA) else $error("oversized read not aborted");
	ird_success_a: assert property (ce && ird_valid && ird_bytes <= MAX_INBOUND_READ_BYTES
		|=> ird_done && ird_status == pre_pkg::CPL_SC) else $error("legal read refused");
	cpl_first_a: assert property (ce && cpl_valid
		|=> resp_valid && !resp_err && resp_tag == $past(cpl_tag)) else $error("completion late");
	cto_later_a: assert property (ce && cpl_valid && cto_valid
		|=> ##[1:8] resp_valid && resp_err) else $error("held timeout lost");
	ok_cause_a: assert property (resp_valid && !resp_err && $past(ce)
		|-> $past(cpl_valid)) else $error("answer without completion");
endmodule // pre_top_chk

bind pre_top pre_top_chk #(.MAX_INBOUND_READ_BYTES(MAX_INBOUND_READ_BYTES)) pre_top_chk_i (.*);

/* pre_far.sv */
// Far-side model: message senders, completion and timeout source, inbound reads.
// Assumes the bench calls one task at a time; the bench may pulse MSI itself.
`timescale 1ns/1ps
module pre_far #(
	parameter int TMO = 8
) (
	// Clock and service indication
	input  wire logic  clk,
	input  wire logic  svc,
	// Messages
	output logic       msi_valid,
	output logic [5:0] msi_vector,
	output logic       pme_valid,
	output logic [15:0] pme_rid,
	// Completions, timeouts and inbound reads
	output logic       cpl_valid,
	output logic [7:0] cpl_tag,
	output logic       cto_valid,
	output logic [7:0] cto_tag,
	output logic       ird_valid,
	output logic [12:0] ird_bytes
);
	// ----------------------------------------
	// Senders.
	// ----------------------------------------
	initial begin
		{msi_valid, pme_valid, cpl_valid, cto_valid, ird_valid} = 5'h0;
		{msi_vector, pme_rid, cpl_tag, cto_tag, ird_bytes} = '0;
	end
	task automatic pme(input logic [15:0] rid);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			pme_valid <= 1'b1;
			pme_rid <= rid;
			@(posedge clk);
			pme_valid <= 1'b0;
			pme_rid <= ~rid;
			for (int n = 0; n < TMO && !svc; n++)
				@(posedge clk);
			if (svc)
				break;
		end
	endtask
	task automatic bridge(input logic c, input logic [7:0] ct, input logic t, input logic [7:0] tt);
		@(posedge clk);
		cpl_valid <= c;
		cpl_tag <= c ? ct : ~cpl_tag;
		cto_valid <= t;
		cto_tag <= t ? tt : ~cto_tag;
	endtask
	task automatic ird(input logic [12:0] b);
		@(posedge clk);
		ird_valid <= 1'b1;
		ird_bytes <= b;
		@(posedge clk);
		ird_valid <= 1'b0;
		ird_bytes <= ~b;
	endtask
endmodule // pre_far

/* pre_top_tb.sv */
// Self-checking bench for pre_top with a register master and a reference model.
// Assumes pre_pkg, pre_top, pre_far and the checker are compiled before it.
`timescale 1ns/1ps
module pre_top_tb;
	localparam int MAXB = 64;
	logic        clk = 1'b0, srst = 1'b1, ce = 1'b1, svc = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, cpl_tag, cto_tag, resp_tag;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rq[$], iq[$], eq[$], tq[$];
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, resp_valid, resp_err, ird_done;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        msi_valid, pme_valid, cpl_valid, cto_valid, ird_valid;
	logic [5:0]  msi_vector;
	logic [15:0] pme_rid;
	logic [12:0] ird_bytes;
	logic [2:0]  ird_status;
	int          failures = 0, checks_done = 0;

	always #12.5 clk = ~clk;
	pre_top #(.MAX_INBOUND_READ_BYTES(MAXB)) pre_top_i (.*);
	pre_far #(.TMO(8)) pre_far_i (.*);
	always @(posedge clk) begin
		if (resp_valid)
			rq.push_back(32'({resp_err, resp_tag}));
		if (ird_done)
			iq.push_back(32'(ird_status));
	end

	// ----------------------------------------
	// Shared tasks.
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic stop();
		failures++;
		summarize();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic m, input logic [5:0] v);
		int n = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		pre_far_i.msi_valid <= m;
		pre_far_i.msi_vector <= v;
		do begin
			@(posedge clk);
			n++;
		end while (!(s_axi_awready && s_axi_wready) && n < 200);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		pre_far_i.msi_valid <= 1'b0;
		pre_far_i.msi_vector <= ~v;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (!s_axi_bvalid && n < 400);
		chk("write response", 32'(s_axi_bresp), 32'(pre_pkg::RESP_OKAY));
		s_axi_bready <= 1'b0;
		if (n >= 400)
			stop();
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (!s_axi_arready && n < 200);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (!s_axi_rvalid && n < 400);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 400)
			stop();
	endtask

	initial begin
		logic [31:0] seed, d, m, vec [2];
		logic [15:0] rid [3];
		logic [12:0] sz [5];
		logic [5:0]  v;
		logic [1:0]  r;
		logic        b, c, t;
		int          nto;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		seed = 32'h7389b281;
		nto = 0;
		vec = '{32'h0, 32'h0};
		rd(pre_pkg::A_CTRL, d, r);
		chk("control reset", d, pre_pkg::CTRL_RST);
		rd(8'h14, d, r);
		chk("unmapped response", 32'(r), 32'(pre_pkg::RESP_DECERR));
		for (int i = 0; i < 32; i++) begin
			seed = lfsr(seed);
			v = seed[5:0];
			m = seed & lfsr(seed);
			b = (i % 4 == 0) ? v[5] : seed[6];
			if (i % 4 == 0)
				m[v[4:0]] = 1'b1;
			wr(pre_pkg::A_VEC0 + 8'(4 * b), m, 1'b1, v);
			vec[b] &= ~m;
			vec[v[5]][v[4:0]] = 1'b1;
			for (int k = 0; k < 2; k++) begin
				rd(pre_pkg::A_VEC0 + 8'(4 * k), d, r);
				chk("vector bank", d, vec[k]);
			end
		end
		for (int k = 0; k < 2; k++) begin
			wr(pre_pkg::A_VEC0 + 8'(4 * k), 32'hffffffff, 1'b0, 6'h0);
			rd(pre_pkg::A_VEC0 + 8'(4 * k), d, r);
			chk("vector cleared", d, 32'h0);
		end
		for (int k = 0; k < 2; k++) begin
			if (k == 1)
				wr(pre_pkg::A_CTRL, 32'h0, 1'b0, 6'h0);
			@(posedge clk);
			ce <= 1'(k);
			pre_far_i.msi_valid <= 1'b1;
			pre_far_i.msi_vector <= 6'h05;
			@(posedge clk);
			ce <= 1'b1;
			pre_far_i.msi_valid <= 1'b0;
		end
		wr(pre_pkg::A_CTRL, 32'h1, 1'b0, 6'h0);
		rd(pre_pkg::A_VEC0, d, r);
		chk("frozen or masked vector", d, 32'h0);
		for (int k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			rid[k] = seed[15:0];
			pre_far_i.pme(rid[k]);
		end
		for (int k = 0; k < 4; k++) begin
			rd(pre_pkg::A_ROOTST, d, r);
			if (k < 3)
				chk("root status", d & 32'h3ffff, {14'h0, k < 2, 1'b1, rid[k]});
			else
				chk("root flags", d & 32'h30000, 32'h0);
			wr(pre_pkg::A_ROOTST, 32'h10000, 1'b0, 6'h0);
		end
		for (int n = 0; n < 2; n++) begin
			rq.delete();
			eq.delete();
			for (int k = 0; k < 4; k++) begin
				seed = lfsr(seed);
				c = n == 0 ? k < 2 : seed[0];
				t = n == 0 ? k < 3 : seed[1];
				pre_far_i.bridge(c, seed[15:8], t, seed[23:16]);
				if (t)
					tq.push_back(32'h100 | seed[23:16]);
				if (c)
					eq.push_back(32'(seed[15:8]));
				else if (tq.size() > 0)
					eq.push_back(tq.pop_front());
				nto += int'(t);
			end
			pre_far_i.bridge(1'b0, 8'h0, 1'b0, 8'h0);
			while (tq.size() > 0)
				eq.push_back(tq.pop_front());
			repeat (10) @(posedge clk);
			chk("answer count", 32'(rq.size()), 32'(eq.size()));
			foreach (eq[j])
				chk("bridge answer", rq[j], eq[j]);
		end
		rd(pre_pkg::A_BRSTAT, d, r);
		chk("timeout count", d & 32'h2ffff, 32'h20000 | 32'(nto));
		seed = lfsr(seed);
		sz = '{13'h1, 13'(MAXB), 13'(MAXB + 1), 13'h1fff, seed[12:0]};
		foreach (sz[k])
			pre_far_i.ird(sz[k]);
		repeat (3) @(posedge clk);
		chk("read count", 32'(iq.size()), 32'h5);
		foreach (sz[k])
			chk("read status", iq[k], sz[k] > MAXB ? 32'h4 : 32'h0);
		summarize();
	end
endmodule // pre_top_tb
